// [rtl/orf_out_ctrl.sv]
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module orf_out_ctrl
   import orf_pkg::*;
#(
   parameter int SLOT_CYC = orf_pkg::ORF_SLOT_CYC,
   parameter int PON_CYC = orf_pkg::ORF_PON_CYC
) (
   input wire logic clk_sys_i, // System clock, 125 MHz.
   input wire logic arst_n_i, // Async reset, active low.
   input wire logic ce_i, // Clock enable; low freezes state.
   input wire logic [orf_pkg::ORF_DW-1:0] bridge_i, // Conditioned bridge result.
   input wire logic [orf_pkg::ORF_DW-1:0] temp_i, // Conditioned temperature result.
   input wire logic [orf_pkg::ORF_DW-1:0] half_i, // Conditioned half-bridge result.
   input wire logic [orf_pkg::ORF_NFAULT-1:0] fault_i, // Supervision check failures.
   input wire logic fault_level_select_i, // Pin, high when open (pull-up).
   input wire logic owl_rx_i, // One-wire link data sampled on primary pin.
   input wire logic owl_tx_i, // One-wire link transmit data.
   input wire logic owl_active_i, // One-wire link session active.
   input wire logic [orf_pkg::ORF_AW-1:0] addr_i, // Register address.
   input wire logic [orf_pkg::ORF_DW-1:0] wdata_i, // Write data.
   input wire logic wr_i, // Write strobe.
   input wire logic rd_i, // Read strobe.
   output logic [orf_pkg::ORF_DW-1:0] rdata_o, // Read data, cycle after strobe.
   output logic [orf_pkg::ORF_DW-1:0] primary_output_o, // Primary channel code.
   output logic primary_oe_o, // High while device drives primary pin.
   output logic owl_rx_o, // Synchronised one-wire link data.
   output logic [orf_pkg::ORF_DW-1:0] secondary_output_o, // Secondary channel code.
   output logic diagnostic_state_o, // Diagnostic state active.
   output logic irq_o // Level interrupt.
);
   import orf_pkg::*;

   function automatic logic [ORF_DW-1:0] trunc13(input logic [ORF_DW-1:0] v);
      trunc13 = {3'b000, v[ORF_DW-1 -: ORF_SENSE_W]};
   endfunction : trunc13

   // Pin synchronisers: three stages, change accepted when stages two and three agree.
   logic [2:0] fls_q, owl_q;
   logic fls_st_q, fls_st_d, owl_st_q, owl_st_d;
   always_comb begin
      fls_st_d = (fls_q[1] == fls_q[2]) ? fls_q[2] : fls_st_q;
      owl_st_d = (owl_q[1] == owl_q[2]) ? owl_q[2] : owl_st_q;
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fls_q <= 3'b111;
         owl_q <= 3'b000;
         fls_st_q <= 1'b1;
         owl_st_q <= 1'b0;
      end else if (ce_i) begin
         fls_q <= {fls_q[1:0], fault_level_select_i};
         owl_q <= {owl_q[1:0], owl_rx_i};
         fls_st_q <= fls_st_d;
         owl_st_q <= owl_st_d;
      end
   end

   // Registers.
   logic [ORF_DW-1:0] cfg_q, cfg_d, ien_q, ien_d, rdata_q, rdata_d;
   logic [ORF_NFAULT-1:0] stat_q, stat_d, fault_q, fault_d;
   logic dm_q, dm_d, irq_q, irq_d;
   orf_src_e src;
   assign src = orf_src_e'(cfg_q[ORF_CFG_SRC_LSB +: 2]);

   always_comb begin
      cfg_d = cfg_q;
      ien_d = ien_q;
      fault_d = fault_i;
      stat_d = stat_q;
      rdata_d = '0;
      if (wr_i && addr_i == ORF_REG_CFG) begin
         cfg_d = wdata_i;
      end
      if (wr_i && addr_i == ORF_REG_IEN) begin
         ien_d = wdata_i;
      end
      if (wr_i && addr_i == ORF_REG_CLR) begin
         stat_d = stat_d & ~wdata_i[ORF_NFAULT-1:0];
      end
      stat_d = stat_d | fault_q; // Set wins over clear.
      // Bits 0..3 sensor checks, 4..7 logic and memory checks.
      dm_d = dm_q | (|fault_q);
      irq_d = |(stat_q & ien_q[ORF_NFAULT-1:0]);
      if (rd_i) begin
         case (addr_i)
            ORF_REG_CFG: rdata_d = cfg_q;
            ORF_REG_STAT: rdata_d = {{(ORF_DW-ORF_NFAULT){1'b0}}, stat_q};
            ORF_REG_IEN: rdata_d = ien_q;
            ORF_REG_BRG: rdata_d = trunc13(bridge_i);
            ORF_REG_TMP: rdata_d = trunc13(temp_i);
            ORF_REG_HBR: rdata_d = trunc13(half_i);
            ORF_REG_SUP: rdata_d = {13'h0000, owl_active_i, fls_st_q, dm_q};
            default: rdata_d = '0;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q <= ORF_CFG_RST;
         ien_q <= '0;
         stat_q <= '0;
         fault_q <= '0;
         dm_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= '0;
      end else if (ce_i) begin
         cfg_q <= cfg_d;
         ien_q <= ien_d;
         stat_q <= stat_d;
         fault_q <= fault_d;
         dm_q <= dm_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   // Power-on diagnostic waveform and sequential slot timers.
   logic [31:0] pon_cnt_q, pon_cnt_d, slot_cnt_q, slot_cnt_d;
   logic pon_q, pon_d;
   orf_slot_e slot_q, slot_d;
   always_comb begin
      pon_d = pon_q;
      pon_cnt_d = pon_cnt_q;
      if (pon_q) begin
         if (!cfg_q[ORF_CFG_PON_BIT] || pon_cnt_q == 32'(PON_CYC - 1)) begin
            pon_d = 1'b0;
         end else begin
            pon_cnt_d = pon_cnt_q + 32'd1;
         end
      end
      slot_d = slot_q;
      slot_cnt_d = slot_cnt_q;
      if (src != ORF_SRC_SEQ || dm_q) begin
         slot_d = ORF_SLOT_FBL;
         slot_cnt_d = '0;
      end else if (slot_cnt_q == 32'(SLOT_CYC - 1)) begin
         slot_cnt_d = '0;
         case (slot_q)
            ORF_SLOT_FBL: slot_d = ORF_SLOT_FBH;
            ORF_SLOT_FBH: slot_d = ORF_SLOT_SIG;
            ORF_SLOT_SIG: slot_d = ORF_SLOT_CHK;
            ORF_SLOT_CHK: slot_d = ORF_SLOT_FBL;
            default: slot_d = ORF_SLOT_FBL;
         endcase
      end else begin
         slot_cnt_d = slot_cnt_q + 32'd1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pon_q <= 1'b1;
         pon_cnt_q <= '0;
         slot_q <= ORF_SLOT_FBL;
         slot_cnt_q <= '0;
      end else if (ce_i) begin
         pon_q <= pon_d;
         pon_cnt_q <= pon_cnt_d;
         slot_q <= slot_d;
         slot_cnt_q <= slot_cnt_d;
      end
   end

   // Channel sources and filters.
   logic [ORF_DW-1:0] func_br, sec_raw, pri_f, sec_f, fb_lvl, pon_lvl;
   assign func_br = ~bridge_i; // Complementary bridge function.
   assign fb_lvl = fls_st_q ? ORF_FB_LOW : ORF_FB_HIGH;
   assign pon_lvl = pon_cnt_q[16] ? ORF_DIAG_HI : ORF_DIAG_LO;
   always_comb begin
      case (src)
         ORF_SRC_TEMP: sec_raw = temp_i;
         ORF_SRC_HALF: sec_raw = half_i;
         ORF_SRC_FUNC: sec_raw = func_br;
         default: sec_raw = func_br;
      endcase
   end
   orf_lpf #(.DW(ORF_DW)) u_lpf_pri (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .en_i(cfg_q[ORF_CFG_FILT1_BIT]), .shift_i(cfg_q[ORF_CFG_SHIFT_LSB +: 4]),
      .x_i(bridge_i), .y_o(pri_f));
   orf_lpf #(.DW(ORF_DW)) u_lpf_sec (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .en_i(cfg_q[ORF_CFG_FILT2_BIT]), .shift_i(cfg_q[ORF_CFG_SHIFT_LSB +: 4]),
      .x_i(sec_raw), .y_o(sec_f));

   logic [ORF_DW-1:0] pri_q, pri_d, sec_q, sec_d;
   logic oe_q, oe_d, owo_q;
   always_comb begin
      pri_d = pri_f;
      oe_d = ~owl_active_i | owl_tx_i;
      if (src == ORF_SRC_SEQ) begin
         case (slot_q)
            ORF_SLOT_FBL: sec_d = ORF_FB_LOW;
            ORF_SLOT_FBH: sec_d = ORF_FB_HIGH;
            ORF_SLOT_SIG: sec_d = cfg_q[ORF_CFG_SEQSRC_BIT] ? half_i : temp_i;
            ORF_SLOT_CHK: sec_d = func_br;
            default: sec_d = ORF_FB_LOW;
         endcase
      end else begin
         sec_d = sec_f;
      end
      if (pon_q) begin
         pri_d = pon_lvl;
         sec_d = pon_lvl;
      end
      if (dm_q) begin
         pri_d = fb_lvl;
         sec_d = fb_lvl;
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pri_q <= ORF_FB_LOW;
         sec_q <= ORF_FB_LOW;
         oe_q <= 1'b1;
         owo_q <= 1'b0;
      end else if (ce_i) begin
         pri_q <= pri_d;
         sec_q <= sec_d;
         oe_q <= oe_d;
         owo_q <= owl_st_q;
      end
   end

   assign primary_output_o = pri_q;
   assign secondary_output_o = sec_q;
   assign primary_oe_o = oe_q;
   assign owl_rx_o = owo_q;
   assign diagnostic_state_o = dm_q;
   assign irq_o = irq_q;
   assign rdata_o = rdata_q;

   property p_dm_force;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (dm_q && ce_i) |=> (primary_output_o == $past(fb_lvl))
         && (secondary_output_o == $past(fb_lvl));
   endproperty
   a_dm_force: assert property (p_dm_force) else $error("fault band not forced");
   property p_dm_entry;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      ((|fault_i) && ce_i) ##1 ce_i |=> diagnostic_state_o;
   endproperty
   a_dm_entry: assert property (p_dm_entry) else $error("fault missed");
   property p_low;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (dm_q && fls_st_q && ce_i) |=> primary_output_o == ORF_FB_LOW;
   endproperty
   a_low: assert property (p_low) else $error("low band wrong");
   property p_high;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (dm_q && !fls_st_q && ce_i) |=> secondary_output_o == ORF_FB_HIGH;
   endproperty
   a_high: assert property (p_high) else $error("high band wrong");
   property p_pri;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (!dm_q && !pon_q && ce_i) |=> primary_output_o == $past(pri_f);
   endproperty
   a_pri: assert property (p_pri) else $error("primary not bridge");
   property p_seq_order;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (slot_q == ORF_SLOT_FBL && $past(slot_q) == ORF_SLOT_FBH) |-> 1'b0;
   endproperty
   a_seq_order: assert property (p_seq_order) else $error("bad slot order");
   property p_seq_chk;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (src == ORF_SRC_SEQ && slot_q == ORF_SLOT_CHK && !dm_q && !pon_q && ce_i)
      |=> secondary_output_o == $past(func_br);
   endproperty
   a_seq_chk: assert property (p_seq_chk) else $error("check slot wrong");
   property p_rd13;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (rd_i && ce_i && addr_i == ORF_REG_BRG) |=> rdata_o[ORF_DW-1 -: 3] == 3'b000;
   endproperty
   a_rd13: assert property (p_rd13) else $error("readout wider than 13 bits");
   property p_pon;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (pon_q && !dm_q && ce_i)
      |=> (primary_output_o == $past(pon_lvl)) && (secondary_output_o == $past(pon_lvl));
   endproperty
   a_pon: assert property (p_pon) else $error("power-on waveform missing");
   property p_seq_fbh;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (src == ORF_SRC_SEQ && slot_q == ORF_SLOT_FBH && !dm_q && !pon_q && ce_i)
      |=> secondary_output_o == ORF_FB_HIGH;
   endproperty
   a_seq_fbh: assert property (p_seq_fbh) else $error("high band slot wrong");
   property p_seq_sig;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (src == ORF_SRC_SEQ && slot_q == ORF_SLOT_SIG && !dm_q && !pon_q && ce_i)
      |=> secondary_output_o == $past(cfg_q[ORF_CFG_SEQSRC_BIT] ? half_i : temp_i);
   endproperty
   a_seq_sig: assert property (p_seq_sig) else $error("signal slot wrong");
   c_dm: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) $rose(dm_q));
   c_seq: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      slot_q == ORF_SLOT_CHK ##1 slot_q == ORF_SLOT_FBL);
   c_pon: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) $fell(pon_q));
endmodule : orf_out_ctrl
`default_nettype wire

// [rtl/orf_pkg.sv]
`default_nettype none
package orf_pkg;
   localparam int ORF_DW = 16;
   localparam int ORF_SENSE_W = 13;
   localparam int ORF_AW = 4;
   localparam logic [ORF_DW-1:0] ORF_FB_LOW = 16'h0666;
   localparam logic [ORF_DW-1:0] ORF_FB_HIGH = 16'hF999;
   localparam logic [ORF_DW-1:0] ORF_DIAG_LO = 16'h0000;
   localparam logic [ORF_DW-1:0] ORF_DIAG_HI = 16'hFFFF;
   localparam int ORF_CLK_MHZ = 125;
   localparam int ORF_SLOT_US = 1000;
   localparam int ORF_SLOT_CYC = ORF_SLOT_US * ORF_CLK_MHZ;
   localparam int ORF_PON_US = 2000;
   localparam int ORF_PON_CYC = ORF_PON_US * ORF_CLK_MHZ;
   localparam logic [ORF_AW-1:0] ORF_REG_CFG = 4'h0;
   localparam logic [ORF_AW-1:0] ORF_REG_STAT = 4'h1;
   localparam logic [ORF_AW-1:0] ORF_REG_CLR = 4'h2;
   localparam logic [ORF_AW-1:0] ORF_REG_IEN = 4'h3;
   localparam logic [ORF_AW-1:0] ORF_REG_BRG = 4'h4;
   localparam logic [ORF_AW-1:0] ORF_REG_TMP = 4'h5;
   localparam logic [ORF_AW-1:0] ORF_REG_HBR = 4'h6;
   localparam logic [ORF_AW-1:0] ORF_REG_SUP = 4'h7;
   // The power-on waveform is enabled out of reset; clearing bit 5 cuts it short.
   localparam logic [ORF_DW-1:0] ORF_CFG_RST = 16'h0020;
   localparam int ORF_CFG_SRC_LSB = 0;
   localparam int ORF_CFG_SEQSRC_BIT = 2;
   localparam int ORF_CFG_FILT1_BIT = 3;
   localparam int ORF_CFG_FILT2_BIT = 4;
   localparam int ORF_CFG_PON_BIT = 5;
   localparam int ORF_CFG_SHIFT_LSB = 8;
   localparam int ORF_NFAULT = 8;
   typedef enum logic [1:0] {
      ORF_SRC_TEMP = 2'b00,
      ORF_SRC_HALF = 2'b01,
      ORF_SRC_FUNC = 2'b10,
      ORF_SRC_SEQ = 2'b11
   } orf_src_e;
   typedef enum logic [1:0] {
      ORF_SLOT_FBL = 2'b00,
      ORF_SLOT_FBH = 2'b01,
      ORF_SLOT_SIG = 2'b10,
      ORF_SLOT_CHK = 2'b11
   } orf_slot_e;
endpackage : orf_pkg
`default_nettype wire

// [rtl/orf_lpf.sv]
`timescale 1ns/100ps
`default_nettype none
// First-order low-pass: y += (x - y) >> shift, bypassed when disabled.
module orf_lpf #(
   parameter int DW = 16
) (
   input wire logic clk_sys_i, // System clock.
   input wire logic arst_n_i, // Async reset, active low.
   input wire logic ce_i, // Clock enable.
   input wire logic en_i, // Filter enable.
   input wire logic [3:0] shift_i, // Filter strength.
   input wire logic [DW-1:0] x_i, // Input sample.
   output logic [DW-1:0] y_o // Filtered value.
);
   logic [DW-1:0] y_q, y_d;
   logic signed [DW+1:0] diff;
   always_comb begin
      diff = $signed({2'b00, x_i}) - $signed({2'b00, y_q});
      if (!en_i) begin
         y_d = x_i;
      end else begin
         y_d = y_q + DW'(diff >>> shift_i);
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         y_q <= '0;
      end else if (ce_i) begin
         y_q <= y_d;
      end
   end
   assign y_o = y_q;
endmodule : orf_lpf
`default_nettype wire

// [tb/orf_ecu_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Control unit side: straps the fault-level pin and drives the one-wire line.
module orf_ecu_model (
   input wire logic strap_gnd_i, // High ties the select pin to analog ground.
   input wire logic tx_i, // One-wire bit sent by the control unit.
   output logic fault_level_select_o, // Select pin level.
   output logic owl_rx_o // Primary pin level seen by the device.
);
   // An open pin floats high through the pull-up and asks for the low band.
   assign fault_level_select_o = !strap_gnd_i;
   assign owl_rx_o = tx_i;
endmodule : orf_ecu_model
`default_nettype wire

// [tb/test_orf_out_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module test_orf_out_ctrl;
   import orf_pkg::*;
   localparam int SLOT = 8;
   logic clk_sys_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, rd_p = 0;
   logic gnd = 0, tx = 0, act = 0, ce = 1, sel, owl, oe, owl_o, dm, irq;
   logic [ORF_AW-1:0] addr_i = '0;
   logic [ORF_DW-1:0] wdata_i = '0, br = '0, tp = '0, hb = '0, rdata, po, so, e_w, fz;
   logic [ORF_DW-1:0] exp_q[$], smp[80], ex[4];
   logic [ORF_NFAULT-1:0] flt = '0;
   logic [31:0] rs = 32'd22110;
   int n_fail = 0, checks_done = 0, cyc = 0, p;

   orf_ecu_model ecu (.strap_gnd_i(gnd), .tx_i(tx), .fault_level_select_o(sel), .owl_rx_o(owl));
   orf_out_ctrl #(.SLOT_CYC(SLOT), .PON_CYC(64)) dut (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce),
      .bridge_i(br), .temp_i(tp), .half_i(hb), .fault_i(flt),
      .fault_level_select_i(sel), .owl_rx_i(owl), .owl_tx_i(tx), .owl_active_i(act),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
      .primary_output_o(po), .primary_oe_o(oe), .owl_rx_o(owl_o),
      .secondary_output_o(so), .diagnostic_state_o(dm), .irq_o(irq));

   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick

   task automatic do_reset();
      @(posedge clk_sys_i);
      arst_n_i <= 1'b0;
      tick(8);
      arst_n_i <= 1'b1;
   endtask : do_reset

   task automatic wr(input logic [ORF_AW-1:0] a, input logic [ORF_DW-1:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ORF_AW-1:0] a, input logic [ORF_DW-1:0] e);
      @(posedge clk_sys_i);
      exp_q.push_back(e);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
   endtask : rd

   task automatic new_in();
      @(posedge clk_sys_i);
      rs = xs(rs);
      br <= rs[15:0];
      tp <= rs[31:16];
      rs = xs(rs);
      hb <= rs[15:0];
   endtask : new_in

   // Samples the secondary channel, locks onto a low-band start, then walks the slots.
   task automatic seq_chk(input logic [ORF_DW-1:0] sig);
      ex = '{ORF_FB_LOW, ORF_FB_HIGH, sig, ~br};
      for (int i = 0; i < 80; i++) begin
         @(negedge clk_sys_i);
         smp[i] = so;
      end
      p = 1;
      while (p < 32 && !(smp[p] === ORF_FB_LOW && smp[p-1] !== ORF_FB_LOW)) p++;
      for (int i = 0; i < 48; i++) `CHK("sequence", ex[(i / SLOT) % 4], smp[p + i])
   endtask : seq_chk

   // Read data stand only in the cycle after the strobe and are zero elsewhere.
   always @(posedge clk_sys_i) rd_p <= rd_i;
   always @(negedge clk_sys_i) begin
      if (rd_p) begin
         e_w = exp_q.pop_front();
         `CHK("rdata", e_w, rdata)
      end else `CHK("rdata idle", 16'h0000, rdata)
   end

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      tick(2);
      @(negedge clk_sys_i);
      `CHK("primary in reset", ORF_FB_LOW, po)
      `CHK("oe in reset", 1'b1, oe)
      do_reset();
      tick(1);
      @(negedge clk_sys_i);
      `CHK("power-on primary", ORF_DIAG_LO, po)
      `CHK("power-on secondary", ORF_DIAG_LO, so)
      rd(ORF_REG_CFG, ORF_CFG_RST);
      rd(ORF_REG_STAT, 16'h0000);
      rd(ORF_REG_IEN, 16'h0000);
      rd(ORF_REG_CLR, 16'h0000);
      for (int a = 8; a < 16; a++) rd(ORF_AW'(a), 16'h0000);
      for (int s = 0; s < 3; s++) begin
         new_in();
         wr(ORF_REG_CFG, 16'(s));
         tick(4);
         @(negedge clk_sys_i);
         `CHK("primary", br, po)
         `CHK("secondary", (s == 0) ? tp : (s == 1) ? hb : ~br, so)
         rd(ORF_REG_BRG, {3'b000, br[15:3]});
         rd(ORF_REG_TMP, {3'b000, tp[15:3]});
         rd(ORF_REG_HBR, {3'b000, hb[15:3]});
      end
      // A low clock enable must hold the primary output while the inputs move.
      @(negedge clk_sys_i);
      fz = po;
      @(posedge clk_sys_i);
      ce <= 1'b0;
      new_in();
      tick(4);
      @(negedge clk_sys_i);
      `CHK("frozen primary", fz, po)
      @(posedge clk_sys_i);
      ce <= 1'b1;
      wr(ORF_REG_CFG, 16'h0218);
      new_in();
      tick(2);
      @(negedge clk_sys_i);
      `CHK("filter lag", 1'b1, po !== br)
      tick(80);
      @(negedge clk_sys_i);
      `CHK("filter settle", 1'b1, ((po > br) ? po - br : br - po) <= 16'd4)
      `CHK("filter settle 2", 1'b1, ((so > tp) ? so - tp : tp - so) <= 16'd4)
      for (int b = 0; b < 2; b++) begin
         wr(ORF_REG_CFG, (b == 1) ? 16'h0007 : 16'h0003);
         seq_chk((b == 1) ? hb : tp);
      end
      for (int b = 0; b < 2; b++) begin
         @(posedge clk_sys_i);
         tx <= (b == 0);
         act <= 1'b1;
         tick(6);
         @(negedge clk_sys_i);
         `CHK("one-wire rx", (b == 0), owl_o)
         `CHK("primary drive", (b == 0), oe)
      end
      rd(ORF_REG_SUP, 16'h0006);
      wr(ORF_REG_IEN, 16'h0001);
      @(posedge clk_sys_i);
      flt <= 8'h01;
      tick(4);
      @(negedge clk_sys_i);
      `CHK("diag", 1'b1, dm)
      `CHK("primary band", ORF_FB_LOW, po)
      `CHK("secondary band", ORF_FB_LOW, so)
      `CHK("irq raised", 1'b1, irq)
      rd(ORF_REG_STAT, 16'h0001);
      wr(ORF_REG_CLR, 16'h0001);
      rd(ORF_REG_STAT, 16'h0001);
      @(posedge clk_sys_i);
      flt <= 8'h10;
      tick(3);
      wr(ORF_REG_CLR, 16'h0001);
      tick(2);
      @(negedge clk_sys_i);
      `CHK("irq masked", 1'b0, irq)
      rd(ORF_REG_STAT, 16'h0010);
      wr(ORF_REG_IEN, 16'h0010);
      tick(2);
      @(negedge clk_sys_i);
      `CHK("irq enabled", 1'b1, irq)
      @(posedge clk_sys_i);
      flt <= 8'h00;
      tick(3);
      wr(ORF_REG_CLR, 16'h00FF);
      tick(2);
      @(negedge clk_sys_i);
      `CHK("irq cleared", 1'b0, irq)
      `CHK("diag sticky", 1'b1, dm)
      wr(ORF_REG_STAT, 16'h00FF);
      rd(ORF_REG_STAT, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_i);
         gnd <= (i % 2 == 1);
         do_reset();
         tick(4);
         flt <= 8'(1 << i);
         tick(4);
         @(negedge clk_sys_i);
         `CHK("primary fault", (i % 2 == 1) ? ORF_FB_HIGH : ORF_FB_LOW, po)
         `CHK("secondary fault", (i % 2 == 1) ? ORF_FB_HIGH : ORF_FB_LOW, so)
         @(posedge clk_sys_i);
         flt <= 8'h00;
      end
      rd(ORF_REG_SUP, 16'h0005);
      tick(2);
      stop_test();
   end
endmodule : test_orf_out_ctrl
`default_nettype wire
